/* File: pkg/cxa_pkg.sv */
// package for the configuration extend access port
`default_nettype none
package cxa_pkg;
    localparam int REG_W = 10;
    localparam int FUNC_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam logic [9:0] LEG_LO = 10'h010;
    localparam logic [9:0] LEG_HI = 10'h01f;
    localparam logic [9:0] EXT_LO = 10'h100;
    localparam logic [9:0] EXT_HI = 10'h3ff;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef struct packed {
        logic [REG_W-1:0] reg_num;
        logic [FUNC_W-1:0] func_num;
        logic [DATA_W-1:0] wdata;
        logic [BE_W-1:0] be;
    } cxa_req_t;

    typedef enum logic [1:0] {
        CXA_IDLE,
        CXA_PULSE,
        CXA_HOLD
    } cxa_state_t;
endpackage
`default_nettype wire

/* File: design/cxa_window_match.sv */
// window decode: does a register index fall in an enabled user range
`timescale 1ns/1ps
`default_nettype none
module cxa_window_match
    import cxa_pkg::*;
(
    input wire logic [9:0] reg_num,
    input wire logic legacy_en,
    input wire logic extended_en,
    output logic hold
);
    logic in_leg;
    logic in_ext;
    always_comb begin
        in_leg = (reg_num >= LEG_LO) && (reg_num <= LEG_HI);
        in_ext = (reg_num >= EXT_LO) && (reg_num <= EXT_HI);
        // indices outside both windows never hold
        hold = (legacy_en && in_leg) || (extended_en && in_ext);
    end
endmodule
`default_nettype wire

/* File: design/cxa_access_port.sv */
// configuration extend access port: forwards link config reads/writes to user logic
`timescale 1ns/1ps
`default_nettype none
module cxa_access_port
    import cxa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic legacy_en,
    input wire logic extended_en,
    input wire logic link_rd,
    input wire logic link_wr,
    input wire cxa_req_t link_req,
    output logic link_busy,
    output logic link_rd_done,
    output logic [DATA_W-1:0] link_rd_data,
    output logic read_received,
    output logic write_received,
    output logic [REG_W-1:0] register_number,
    output logic [FUNC_W-1:0] function_number,
    output logic [DATA_W-1:0] write_data,
    output logic [BE_W-1:0] write_byte_enable,
    input wire logic [DATA_W-1:0] read_data,
    input wire logic read_data_valid
);
    cxa_state_t state_r, state_nxt;
    cxa_req_t req_r, req_nxt;
    logic wr_r, wr_nxt;
    logic done_r, done_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic hold;

    cxa_window_match u_match (
        .reg_num(link_req.reg_num),
        .legacy_en(legacy_en),
        .extended_en(extended_en),
        .hold(hold)
    );

    // the link must wait while a held read is open; a new request is not
    // accepted in that time, so index and function stay stable for the user
    assign link_busy = (state_r == CXA_HOLD);
    // back-to-back pulse reads show as one longer high stretch; the index
    // still moves on every cycle, so user logic must read it per cycle
    assign read_received = (state_r != CXA_IDLE);
    assign write_received = wr_r;
    assign register_number = req_r.reg_num;
    assign function_number = req_r.func_num;
    assign write_data = req_r.wdata;
    assign write_byte_enable = req_r.be;
    // answer pulse and captured word both leave from flops
    assign link_rd_done = done_r;
    assign link_rd_data = rdata_r;

    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        wr_nxt = 1'b0;
        done_nxt = 1'b0;
        rdata_nxt = rdata_r;
        case (state_r)
            CXA_HOLD: begin
                // requests are dropped here, not queued; the link watches link_busy
                // valid sampled on the edge after read raised, and each after
                if (read_data_valid) begin
                    rdata_nxt = read_data;
                    done_nxt = 1'b1;
                    state_nxt = CXA_IDLE;
                end
            end
            default: begin
                state_nxt = CXA_IDLE;
                // a write offered beside a read is lost: reads win the cycle
                if (link_rd) begin
                    req_nxt = link_req;
                    state_nxt = hold ? CXA_HOLD : CXA_PULSE;
                end else if (link_wr) begin
                    req_nxt = link_req;
                    wr_nxt = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        // synchronous reset: every indication starts low
        if (!rst_n) begin
            state_r <= CXA_IDLE;
            req_r <= '0;
            wr_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= RDATA_RST;
        end else begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            wr_r <= wr_nxt;
            done_r <= done_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // assertions: clocked on ref_clk, quiet while rst_n is low

    // with no user range enabled a read is a one-cycle pulse; only a read taken
    // straight after may keep the indication high
    a_short_read_pulse: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r != CXA_HOLD && link_rd && !legacy_en && !extended_en)
        |=> (read_received && !link_busy) ##1 (!read_received || $past(link_rd)))
        else $error("unheld read not a single-cycle pulse");

    a_legacy_read_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (read_received && !read_data_valid && legacy_en
         && register_number >= LEG_LO && register_number <= LEG_HI)
        |=> read_received)
        else $error("legacy read dropped before data valid");

    a_ext_read_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (read_received && !read_data_valid && extended_en
         && register_number >= EXT_LO && register_number <= EXT_HI)
        |=> read_received)
        else $error("extended read dropped before data valid");

    // an index in no window must never hold, whatever the enables say
    a_outside_window: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (read_received && !(register_number >= LEG_LO && register_number <= LEG_HI)
         && !(register_number >= EXT_LO && register_number <= EXT_HI))
        |=> (!read_received || $past(link_rd)))
        else $error("read outside windows held");

    a_unheld_not_busy: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r != CXA_HOLD && link_rd && !hold)
        |=> read_received && !link_busy)
        else $error("unheld read left the link busy");

    // a write is a one-cycle pulse; only a write taken straight after may extend it
    a_write_pulse: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r != CXA_HOLD && !link_rd && link_wr)
        |=> write_received ##1 (!write_received || $past(link_wr && !link_rd)))
        else $error("write not a single-cycle pulse");

    a_write_alone: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        write_received |-> !read_received)
        else $error("write and read indications together");

    // writes offered while a held read is open are dropped
    a_busy_refuse: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (link_busy && link_wr)
        |=> !write_received)
        else $error("write accepted while busy");

    a_read_raise: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r != CXA_HOLD && link_rd)
        |=> read_received)
        else $error("read request not raised");

    // read wins when both requests come in one cycle
    a_read_wins: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r != CXA_HOLD && link_rd && link_wr)
        |=> read_received && !write_received)
        else $error("write taken beside a read");

    a_read_fields: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r != CXA_HOLD && link_rd)
        |=> register_number == $past(link_req.reg_num)
            && function_number == $past(link_req.func_num))
        else $error("read index fields wrong");

    a_index_stable: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (read_received && $past(read_received) && $past(state_r) == CXA_HOLD)
        |-> $stable(register_number) && $stable(function_number))
        else $error("index changed during held read");

    a_wdata_match: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r != CXA_HOLD && !link_rd && link_wr)
        |=> write_data == $past(link_req.wdata) && write_byte_enable == $past(link_req.be)
            && register_number == $past(link_req.reg_num)
            && function_number == $past(link_req.func_num))
        else $error("write fields wrong");

    // the edge after a valid strobe seen in a held read carries the data out
    a_rdata_capture: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r == CXA_HOLD && read_data_valid)
        |=> link_rd_done && link_rd_data == $past(read_data) && !read_received)
        else $error("read data not captured");

    a_done_source: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        link_rd_done |-> ($past(state_r) == CXA_HOLD && $past(read_data_valid)))
        else $error("read done without a held read answered");

    // the captured word stays put between answers
    a_rdata_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !link_rd_done |-> $stable(link_rd_data))
        else $error("captured read data moved");
endmodule
`default_nettype wire

/* File: sim/cxa_user_model.sv */
// user-side model answering held configuration reads
`timescale 1ns/1ps
`default_nettype none
module cxa_user_model
    import cxa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic legacy_en,
    input wire logic extended_en,
    input wire logic read_received,
    input wire logic [REG_W-1:0] register_number,
    input wire logic [1:0] lat,
    output logic [DATA_W-1:0] read_data,
    output logic read_data_valid
);
    logic [1:0] wait_r;
    logic mine;
    assign mine = (legacy_en && register_number >= LEG_LO && register_number <= LEG_HI)
        || (extended_en && register_number >= EXT_LO);
    // driven on the falling edge so an answer can meet the first sampling edge
    always_ff @(negedge ref_clk) begin
        if (!rst_n || !read_received) wait_r <= 2'h0;
        else if (wait_r != 2'h3) wait_r <= wait_r + 2'h1;
        if (!rst_n) begin
            read_data_valid <= 1'b0;
            read_data <= 32'h0;
        end else if (read_data_valid || !read_received || !mine || wait_r < lat) begin
            // idle bus toggles so a stale word never looks valid
            read_data_valid <= 1'b0;
            read_data <= ~read_data;
        end else begin
            read_data_valid <= 1'b1;
            read_data <= 32'h5a00_0000 | 32'(register_number);
        end
    end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the configuration extend access port
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import cxa_pkg::*;
;
    logic ref_clk, rst_n, legacy_en, extended_en, link_rd, link_wr, link_busy, link_rd_done;
    logic read_received, write_received, read_data_valid;
    logic [1:0] lat;
    cxa_req_t link_req;
    logic [DATA_W-1:0] link_rd_data, write_data, read_data;
    logic [REG_W-1:0] register_number;
    logic [FUNC_W-1:0] function_number;
    logic [BE_W-1:0] write_byte_enable;
    logic [9:0] corner [8] = '{10'h00f, 10'h010, 10'h01f, 10'h020, 10'h0ff, 10'h100, 10'h3ff,
        10'h200};
    int bad_count = 0;
    int tests_run = 0;
    cxa_access_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .legacy_en(legacy_en),
        .extended_en(extended_en), .link_rd(link_rd), .link_wr(link_wr), .link_req(link_req),
        .link_busy(link_busy), .link_rd_done(link_rd_done), .link_rd_data(link_rd_data),
        .read_received(read_received), .write_received(write_received),
        .register_number(register_number), .function_number(function_number),
        .write_data(write_data), .write_byte_enable(write_byte_enable), .read_data(read_data),
        .read_data_valid(read_data_valid));
    cxa_user_model u_user (.ref_clk(ref_clk), .rst_n(rst_n), .legacy_en(legacy_en),
        .extended_en(extended_en), .read_received(read_received),
        .register_number(register_number), .lat(lat), .read_data(read_data),
        .read_data_valid(read_data_valid));
    task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    function automatic logic exp_hold(input logic wr, input logic [9:0] rn);
        logic in_leg;
        logic in_ext;
        in_leg = legacy_en && rn >= LEG_LO && rn <= LEG_HI;
        in_ext = extended_en && rn >= EXT_LO && rn <= EXT_HI;
        return !wr && (in_leg || in_ext);
    endfunction
    function automatic logic [31:0] exp_rdata(input logic [9:0] rn);
        return 32'h5a00_0000 | 32'(rn);
    endfunction
    task automatic op(input logic wr, input logic [9:0] rn, input logic [7:0] fn);
        logic hold;
        int n;
        hold = exp_hold(wr, rn);
        link_req = {rn, fn, 32'($urandom), 4'($urandom)};
        link_rd = !wr;
        // a read may carry a write beside it; the read must win
        link_wr = wr || fn[0];
        @(negedge ref_clk);
        link_rd = 1'b0;
        // a write offered while a read is held must be ignored
        link_wr = hold && lat != 2'h0;
        chk("received", {read_received, write_received}, {!wr, wr});
        chk("busy", {link_busy, link_rd_done}, {hold, 1'b0});
        chk("register", register_number, rn);
        chk("function", function_number, fn);
        if (wr) begin
            chk("wdata", {write_data, write_byte_enable},
                {link_req.wdata, link_req.be});
        end
        n = 0;
        while ((read_received || write_received) && n < 20) begin
            @(negedge ref_clk);
            if (n == 0 && link_wr) link_wr = 1'b0;
            n++;
        end
        chk("length", n, hold ? lat + 3'd1 : 3'd1);
        if (hold) chk("rdata", {link_rd_done, link_rd_data}, {1'b1, exp_rdata(rn)});
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end
    initial begin
        {rst_n, legacy_en, extended_en, link_rd, link_wr, lat} = '0;
        link_req = '0;
        void'($urandom(32'hdc557bc6));
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        for (int i = 0; i < 64; i++) begin
            lat = 2'($urandom);
            legacy_en = i < 32 ? i[3] : 1'($urandom);
            extended_en = i < 32 ? i[4] : 1'($urandom);
            op(i >= 32 && 1'($urandom), i < 32 ? corner[i % 8] : 10'($urandom), 8'($urandom));
        end
        wrap_up();
    end
endmodule
`default_nettype wire
